// file: rtl/motion_event_wake_regs.vh
`ifndef MOTION_EVENT_WAKE_REGS_VH
`define MOTION_EVENT_WAKE_REGS_VH
// Oversampling mode encodings
`define OSM_NORMAL        2'h0
`define OSM_LOWNOISE      2'h1
`define OSM_HIRES         2'h2
`define OSM_LOWPOWER      2'h3
// Oversampling ratio per mode (samples averaged per output)
`define OSR_NORMAL        8'h04
`define OSR_LOWNOISE      8'h04
`define OSR_HIRES         8'h10
`define OSR_LOWPOWER      8'h02
// Interrupt source bit positions
`define SRC_DRDY          0
`define SRC_MOTION        2
`define SRC_TAP           3
`define SRC_ORIENT        4
`define SRC_TRANS         5
`define SRC_BUF           6
`define SRC_SLEEP         7
// Orientation codes
`define ORI_PORT_UP       3'h0
`define ORI_PORT_DN       3'h1
`define ORI_LAND_R        3'h2
`define ORI_LAND_L        3'h3
`define ORI_FRONT         3'h4
`define ORI_BACK          3'h5
// Z-lockout settings, degrees
`define ZLOCK_DEFAULT_DEG 8'h1d
`define ZLOCK_MIN_DEG     8'h0e
`endif

// file: rtl/motion_event_wake_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "motion_event_wake_regs.vh"
module motion_event_wake_controller #(
  parameter W         = 12,
  parameter TOUT_W    = 16
) (
  input  wire                clock,
  input  wire                rst,
  input  wire                sampleValid,
  input  wire signed [W-1:0] rawX,
  input  wire signed [W-1:0] rawY,
  input  wire signed [W-1:0] rawZ,
  input  wire signed [W-1:0] trimX,
  input  wire signed [W-1:0] trimY,
  input  wire signed [W-1:0] trimZ,
  input  wire signed [7:0]   userOffX,
  input  wire signed [7:0]   userOffY,
  input  wire signed [7:0]   userOffZ,
  input  wire [1:0]          oversampling_mode_select,
  input  wire [1:0]          oversampling_mode_sleep,
  input  wire                autoSleepEn,
  input  wire [TOUT_W-1:0]   sleepTimeout,
  input  wire [2:0]          wakeRate,
  input  wire [2:0]          sleepRate,
  input  wire                bufGate,
  input  wire                bufEvent,
  input  wire [3:0]          wakeSrcEn,
  input  wire [1:0]          hpCutoff,
  input  wire                ffMotSelMotion,
  input  wire [2:0]          ffMotAxisEn,
  input  wire                motionHpEn,
  input  wire [W-1:0]        ffMotThr,
  input  wire [7:0]          ffMotCount,
  input  wire [2:0]          transAxisEn,
  input  wire                transHpBypass,
  input  wire [W-1:0]        transThr,
  input  wire [7:0]          transCount,
  input  wire [2:0]          tapAxisEn,
  input  wire                tapDoubleEn,
  input  wire                tapHpEn,
  input  wire                tapLpEn,
  input  wire [W-1:0]        tapThrX,
  input  wire [W-1:0]        tapThrY,
  input  wire [W-1:0]        tapThrZ,
  input  wire [7:0]          tapWindow,
  input  wire [7:0]          tapLatency,
  input  wire [W-1:0]        oriMidThr,
  input  wire [W-1:0]        oriHyst,
  input  wire [W-1:0]        zLockThr,
  input  wire [7:0]          interrupt_pin_route_config,
  input  wire [7:0]          intEnable,
  input  wire                rdMotionSrc,
  input  wire                rdTransSrc,
  input  wire                rdTapSrc,
  input  wire                rdOrientSrc,
  input  wire                rdSysSrc,
  input  wire                rdData,
  output reg                 interrupt_out_a,
  output reg                 interrupt_out_b,
  output reg  [7:0]          intSource,
  output reg  [6:0]          motionSrc,
  output reg  [6:0]          transSrc,
  output reg  [7:0]          tapSrc,
  output reg  [2:0]          orientSrc,
  output reg                 sleepState,
  output reg  [2:0]          output_sample_rate,
  output reg  [7:0]          osRatio,
  output reg                 bufHold,
  output reg  signed [W-1:0] corrX,
  output reg  signed [W-1:0] corrY,
  output reg  signed [W-1:0] corrZ
);

  function [W-1:0] absv;
    input signed [W-1:0] v;
    begin
      absv = v[W-1] ? (~v + 1'b1) : v;
    end
  endfunction

  function [7:0] osrOf;
    input [1:0] m;
    begin
      case (m)
        `OSM_HIRES:    osrOf = `OSR_HIRES;
        `OSM_LOWPOWER: osrOf = `OSR_LOWPOWER;
        `OSM_LOWNOISE: osrOf = `OSR_LOWNOISE;
        default:       osrOf = `OSR_NORMAL;
      endcase
    end
  endfunction

  // One-pole high-pass: y = x - lp, lp += (x-lp) >> k
  function signed [W-1:0] hpOut;
    input signed [W-1:0] x;
    input signed [W-1:0] lp;
    begin
      hpOut = x - lp;
    end
  endfunction

  // Offset correction after factory trim
  wire signed [W-1:0] offX = {{(W-8){userOffX[7]}}, userOffX};
  wire signed [W-1:0] offY = {{(W-8){userOffY[7]}}, userOffY};
  wire signed [W-1:0] offZ = {{(W-8){userOffZ[7]}}, userOffZ};
  wire signed [W-1:0] nxt_corrX = rawX + trimX + offX;
  wire signed [W-1:0] nxt_corrY = rawY + trimY + offY;
  wire signed [W-1:0] nxt_corrZ = rawZ + trimZ + offZ;

  // Cutoff shift grows with setting and with the output rate code
  wire [3:0] hpShift = {2'h0, hpCutoff} + {1'b0, output_sample_rate} + 4'h1;
  reg signed [W-1:0] lpX_ff, lpY_ff, lpZ_ff;
  wire signed [W-1:0] hpX = hpOut(corrX, lpX_ff);
  wire signed [W-1:0] hpY = hpOut(corrY, lpY_ff);
  wire signed [W-1:0] hpZ = hpOut(corrZ, lpZ_ff);
  reg sampleDly_ff;

  always @(posedge clock) begin
    if (rst) begin
      corrX <= {W{1'b0}};
      corrY <= {W{1'b0}};
      corrZ <= {W{1'b0}};
      lpX_ff <= {W{1'b0}};
      lpY_ff <= {W{1'b0}};
      lpZ_ff <= {W{1'b0}};
      sampleDly_ff <= 1'b0;
    end else begin
      sampleDly_ff <= sampleValid;
      if (sampleValid) begin
        corrX <= nxt_corrX;
        corrY <= nxt_corrY;
        corrZ <= nxt_corrZ;
      end
      if (sampleDly_ff) begin
        lpX_ff <= lpX_ff + (hpX >>> hpShift);
        lpY_ff <= lpY_ff + (hpY >>> hpShift);
        lpZ_ff <= lpZ_ff + (hpZ >>> hpShift);
      end
    end
  end

  // Freefall: raw data; motion: optional filtered data
  wire signed [W-1:0] mX = motionHpEn ? hpX : corrX;
  wire signed [W-1:0] mY = motionHpEn ? hpY : corrY;
  wire signed [W-1:0] mZ = motionHpEn ? hpZ : corrZ;
  wire [2:0] overM = {absv(mZ) > ffMotThr, absv(mY) > ffMotThr,
                      absv(mX) > ffMotThr} & ffMotAxisEn;
  wire [2:0] underF = {absv(corrZ) < ffMotThr, absv(corrY) < ffMotThr,
                       absv(corrX) < ffMotThr} | ~ffMotAxisEn;
  wire ffmCond = ffMotSelMotion ? (|overM) : (&underF && |ffMotAxisEn);

  wire signed [W-1:0] tX = transHpBypass ? corrX : hpX;
  wire signed [W-1:0] tY = transHpBypass ? corrY : hpY;
  wire signed [W-1:0] tZ = transHpBypass ? corrZ : hpZ;
  wire [2:0] overT = {absv(tZ) > transThr, absv(tY) > transThr,
                      absv(tX) > transThr} & transAxisEn;

  // Tap input: optional high-pass then optional 2-tap low-pass
  reg signed [W-1:0] tapPrvX_ff, tapPrvY_ff, tapPrvZ_ff;
  wire signed [W-1:0] tbX = tapHpEn ? hpX : corrX;
  wire signed [W-1:0] tbY = tapHpEn ? hpY : corrY;
  wire signed [W-1:0] tbZ = tapHpEn ? hpZ : corrZ;
  wire signed [W-1:0] tpX = tapLpEn ? ((tbX >>> 1) + (tapPrvX_ff >>> 1)) : tbX;
  wire signed [W-1:0] tpY = tapLpEn ? ((tbY >>> 1) + (tapPrvY_ff >>> 1)) : tbY;
  wire signed [W-1:0] tpZ = tapLpEn ? ((tbZ >>> 1) + (tapPrvZ_ff >>> 1)) : tbZ;
  wire [2:0] overP = {absv(tpZ) > tapThrZ, absv(tpY) > tapThrY,
                      absv(tpX) > tapThrX} & tapAxisEn;

  // Event and debounce state
  reg [7:0] ffmCnt_ff, transCnt_ff, tapCnt_ff;
  reg [1:0] tapSt_ff;
  reg       tapAbove_ff;
  reg [2:0] tapAxes_ff, tapPol_ff;
  reg [2:0] curOri_ff;
  reg [TOUT_W-1:0] idleCnt_ff;
  reg ffmEv, transEv, tapEv, oriEv, sleepEv;
  reg [2:0] nxt_ori;

  localparam TAP_IDLE = 2'h0;
  localparam TAP_LAT  = 2'h1;
  localparam TAP_WIN2 = 2'h2;

  // Orientation: dominant axis with hysteresis around midpoint
  wire [W-1:0] hiTrip = oriMidThr + oriHyst;
  wire lockout = absv(corrZ) > zLockThr;
  always @* begin
    nxt_ori = curOri_ff;
    if (absv(corrY) > hiTrip && absv(corrY) >= absv(corrX))
      nxt_ori = corrY[W-1] ? `ORI_PORT_DN : `ORI_PORT_UP;
    else if (absv(corrX) > hiTrip)
      nxt_ori = corrX[W-1] ? `ORI_LAND_L : `ORI_LAND_R;
    if (corrZ[W-1] != (curOri_ff == `ORI_BACK) && absv(corrZ) > hiTrip)
      nxt_ori = corrZ[W-1] ? `ORI_BACK : `ORI_FRONT;
  end

  wire wakeHit = |({tapEv, oriEv, ffmEv, transEv} & wakeSrcEn);
  wire keepAwake = wakeHit || (bufEvent && intEnable[`SRC_BUF]);

  always @(posedge clock) begin
    if (rst) begin
      ffmCnt_ff <= 8'h00;
      transCnt_ff <= 8'h00;
      tapCnt_ff <= 8'h00;
      tapSt_ff <= TAP_IDLE;
      tapAbove_ff <= 1'b0;
      tapAxes_ff <= 3'h0;
      tapPol_ff <= 3'h0;
      tapPrvX_ff <= {W{1'b0}};
      tapPrvY_ff <= {W{1'b0}};
      tapPrvZ_ff <= {W{1'b0}};
      curOri_ff <= `ORI_PORT_UP;
      idleCnt_ff <= {TOUT_W{1'b0}};
      ffmEv <= 1'b0;
      transEv <= 1'b0;
      tapEv <= 1'b0;
      oriEv <= 1'b0;
      sleepEv <= 1'b0;
      sleepState <= 1'b0;
      motionSrc <= 7'h00;
      transSrc <= 7'h00;
      tapSrc <= 8'h00;
      orientSrc <= `ORI_PORT_UP;
    end else begin
      ffmEv <= 1'b0;
      transEv <= 1'b0;
      tapEv <= 1'b0;
      oriEv <= 1'b0;
      sleepEv <= 1'b0;
      if (rdMotionSrc) motionSrc <= 7'h00;
      if (rdTransSrc) transSrc <= 7'h00;
      if (rdTapSrc) tapSrc <= 8'h00;
      if (sampleDly_ff) begin
        tapPrvX_ff <= tbX;
        tapPrvY_ff <= tbY;
        tapPrvZ_ff <= tbZ;
        if (!ffmCond)
          ffmCnt_ff <= 8'h00;
        else if (ffmCnt_ff < ffMotCount)
          ffmCnt_ff <= ffmCnt_ff + 8'h01;
        if (ffmCond && ffmCnt_ff + 8'h01 >= ffMotCount) begin
          ffmEv <= 1'b1;
          motionSrc <= {1'b1, overM[2], mZ[W-1], overM[1], mY[W-1],
                        overM[0], mX[W-1]};
        end
        if (~|overT)
          transCnt_ff <= 8'h00;
        else if (transCnt_ff < transCount)
          transCnt_ff <= transCnt_ff + 8'h01;
        if (|overT && transCnt_ff + 8'h01 >= transCount) begin
          transEv <= 1'b1;
          transSrc <= {1'b1, overT[2], tZ[W-1], overT[1], tY[W-1],
                       overT[0], tX[W-1]};
        end
        // Tap: pulse must fall back within window; second within window after latency
        tapAbove_ff <= |overP;
        case (tapSt_ff)
          TAP_IDLE: begin
            if (|overP && !tapAbove_ff) begin
              tapCnt_ff <= 8'h00;
              tapAxes_ff <= overP;
              tapPol_ff <= {tpZ[W-1], tpY[W-1], tpX[W-1]};
            end else if (tapAbove_ff && tapCnt_ff < tapWindow)
              tapCnt_ff <= tapCnt_ff + 8'h01;
            if (tapAbove_ff && !(|overP) && tapCnt_ff < tapWindow) begin
              tapCnt_ff <= 8'h00;
              if (tapDoubleEn) tapSt_ff <= TAP_LAT;
              else begin
                tapEv <= 1'b1;
                tapSrc <= {1'b1, 1'b0, tapAxes_ff, tapPol_ff};
              end
            end
          end
          TAP_LAT: begin
            tapCnt_ff <= tapCnt_ff + 8'h01;
            if (tapCnt_ff >= tapLatency) begin
              tapCnt_ff <= 8'h00;
              tapSt_ff <= TAP_WIN2;
            end
          end
          TAP_WIN2: begin
            tapCnt_ff <= tapCnt_ff + 8'h01;
            if (|overP) begin
              tapEv <= 1'b1;
              tapSrc <= {1'b1, 1'b1, tapAxes_ff | overP, tapPol_ff};
              tapSt_ff <= TAP_IDLE;
            end else if (tapCnt_ff >= tapWindow)
              tapSt_ff <= TAP_IDLE;
          end
          default: tapSt_ff <= TAP_IDLE;
        endcase
        if (!lockout && nxt_ori != curOri_ff) begin
          curOri_ff <= nxt_ori;
          orientSrc <= nxt_ori;
          oriEv <= 1'b1;
        end
      end
      // Auto wake/sleep
      if (!autoSleepEn) begin
        sleepState <= 1'b0;
        idleCnt_ff <= {TOUT_W{1'b0}};
      end else if (keepAwake) begin
        idleCnt_ff <= {TOUT_W{1'b0}};
        if (sleepState && wakeHit) begin
          sleepState <= 1'b0;
          sleepEv <= 1'b1;
        end
      end else if (!sleepState && sampleDly_ff) begin
        if (idleCnt_ff >= sleepTimeout) begin
          sleepState <= 1'b1;
          sleepEv <= 1'b1;
          idleCnt_ff <= {TOUT_W{1'b0}};
        end else
          idleCnt_ff <= idleCnt_ff + {{(TOUT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Sticky flags, set wins over clear
  wire [7:0] evVec = {sleepEv, bufEvent, transEv, oriEv, tapEv, ffmEv,
                      1'b0, sampleValid};
  // A data read flushes the buffer and so also clears its flag
  wire [7:0] clrVec = {rdSysSrc, rdData, rdTransSrc, rdOrientSrc, rdTapSrc,
                       rdMotionSrc, 1'b0, rdData};
  wire [7:0] nxt_src = (intSource & ~clrVec) | (evVec & intEnable);
  wire [7:0] routeA = nxt_src & interrupt_pin_route_config;

  always @(posedge clock) begin
    if (rst) begin
      intSource <= 8'h00;
      interrupt_out_a <= 1'b0;
      interrupt_out_b <= 1'b0;
      output_sample_rate <= 3'h0;
      osRatio <= `OSR_NORMAL;
      bufHold <= 1'b0;
    end else begin
      intSource <= nxt_src & 8'hfd;
      interrupt_out_a <= |(routeA & 8'hfd);
      interrupt_out_b <= |(nxt_src & ~interrupt_pin_route_config & 8'hfd);
      output_sample_rate <= sleepState ? sleepRate : wakeRate;
      osRatio <= osrOf(sleepState ? oversampling_mode_sleep
                                  : oversampling_mode_select);
      // Hold buffer across transitions until flushed by a data read
      if (!bufGate || rdData)
        bufHold <= 1'b0;
      else if (sleepEv)
        bufHold <= 1'b1;
    end
  end

endmodule // motion_event_wake_controller
`default_nettype wire

// file: test/motion_event_wake_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_event_wake_regs.vh"
module motion_event_wake_chk #(parameter W = 12) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                sampleValid,
  input wire logic [1:0]          oversampling_mode_select,
  input wire logic [2:0]          wakeRate,
  input wire logic [2:0]          sleepRate,
  input wire logic [7:0]          interrupt_pin_route_config,
  input wire logic [7:0]          intEnable,
  input wire logic                rdMotionSrc,
  input wire logic                rdSysSrc,
  input wire logic                rdData,
  input wire logic                interrupt_out_a,
  input wire logic                interrupt_out_b,
  input wire logic [7:0]          intSource,
  input wire logic                sleepState,
  input wire logic [2:0]          output_sample_rate,
  input wire logic [7:0]          osRatio,
  input wire logic signed [W-1:0] corrX
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_PIN_A: assert property (
    interrupt_out_a |-> |(intSource & interrupt_pin_route_config))
    else $error("pin a high without a flag routed to it");
  AST_PIN_B: assert property (
    interrupt_out_b |-> |(intSource & ~interrupt_pin_route_config))
    else $error("pin b high without a flag routed to it");
  AST_STICKY: assert property (
    intSource[`SRC_MOTION] && !rdMotionSrc && !rdSysSrc |=>
    intSource[`SRC_MOTION]) else $error("motion flag dropped unread");
  AST_CLEAR: assert property (
    rdMotionSrc |=> !intSource[`SRC_MOTION])
    else $error("motion flag survived its read");
  AST_HIRES: assert property (
    (!sleepState && oversampling_mode_select == `OSM_HIRES)[*3] |->
    osRatio == `OSR_HIRES) else $error("high resolution ratio wrong");
  AST_LOWPWR: assert property (
    (!sleepState && oversampling_mode_select == `OSM_LOWPOWER)[*3] |->
    osRatio == `OSR_LOWPOWER) else $error("low power ratio wrong");
  AST_SLEEP_RATE: assert property (
    sleepState[*3] |-> output_sample_rate == sleepRate)
    else $error("sleep rate not applied");
  AST_WAKE_RATE: assert property (
    $fell(sleepState) |-> ##[0:3] output_sample_rate == wakeRate)
    else $error("wake rate not restored");
  AST_DRDY: assert property (
    sampleValid && intEnable[`SRC_DRDY] && !rdData && !rdSysSrc |=>
    intSource[`SRC_DRDY]) else $error("data ready flag missing");
  AST_CORR: assert property (
    !$past(sampleValid) |-> $stable(corrX))
    else $error("corrected value moved without a sample");
endmodule // motion_event_wake_chk
bind motion_event_wake_controller motion_event_wake_chk #(.W(W)) u_chk (.*);
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       svcOn,
  input  wire logic [3:0] lag,
  input  wire logic       interrupt_out_a,
  input  wire logic       interrupt_out_b,
  input  wire logic [7:0] intSource,
  output logic            rdMotionSrc,
  output logic            rdTransSrc,
  output logic            rdTapSrc,
  output logic            rdOrientSrc,
  output logic            rdSysSrc,
  output logic            rdData
);
  logic [4:0] wait_ff;
  // Waits lag cycles after a pin rises, then reads each flagged source
  always @(posedge clock) begin
    {rdMotionSrc, rdTransSrc, rdTapSrc} <= 3'h0;
    {rdOrientSrc, rdSysSrc, rdData} <= 3'h0;
    if (rst || !svcOn || !(interrupt_out_a || interrupt_out_b)) begin
      wait_ff <= {1'b0, lag};
    end else if (wait_ff != 5'h00) begin
      wait_ff <= wait_ff - 5'h01;
    end else begin
      rdMotionSrc <= intSource[2];
      rdTransSrc  <= intSource[5];
      rdTapSrc    <= intSource[3];
      rdOrientSrc <= intSource[4];
      rdSysSrc    <= intSource[7] | intSource[6];
      rdData      <= intSource[0] | intSource[6];
      wait_ff     <= {1'b0, lag} + 5'h01;
    end
  end
endmodule // host_model
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_event_wake_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; $display("wrong value at %0t got %h exp %h", \
  $time, (a), (b)); end end
module tb_top;
  localparam logic signed [11:0] BIG = 12'sh200;
  localparam logic signed [11:0] NIL = 12'sh000;
  logic clock = 1'b0, rst = 1'b1, svcOn = 1'b0, bufOn = 1'b0;
  logic sampleValid = 0, autoSleepEn = 0, bufGate = 0, bufEvent = 0;
  logic ffMotSelMotion = 0, motionHpEn = 0, transHpBypass = 0;
  logic tapDoubleEn = 0, tapHpEn = 0, tapLpEn = 0;
  logic signed [11:0] rawX = 0, rawY = 0, rawZ = 0;
  logic signed [11:0] trimX = 0, trimY = 0, trimZ = 0;
  logic signed [7:0] userOffX = 0, userOffY = 0, userOffZ = 0;
  logic [1:0] oversampling_mode_select = 0, oversampling_mode_sleep = 0;
  logic [1:0] hpCutoff = 0;
  logic [15:0] sleepTimeout = 0;
  logic [2:0] wakeRate = 0, sleepRate = 0, ffMotAxisEn = 0, transAxisEn = 0;
  logic [2:0] tapAxisEn = 0;
  logic [3:0] wakeSrcEn = 0, lag = 0;
  logic [11:0] ffMotThr = 0, transThr = 0, tapThrX = 0, tapThrY = 0;
  logic [11:0] tapThrZ = 0, oriMidThr = 0, oriHyst = 0, zLockThr = 0;
  logic [7:0] ffMotCount = 0, transCount = 0, tapWindow = 0, tapLatency = 0;
  logic [7:0] interrupt_pin_route_config = 0, intEnable = 0;
  logic rdMotionSrc, rdTransSrc, rdTapSrc, rdOrientSrc, rdSysSrc, rdData;
  logic interrupt_out_a, interrupt_out_b, sleepState, bufHold;
  logic [7:0] intSource, tapSrc, osRatio;
  logic [6:0] motionSrc, transSrc;
  logic [2:0] orientSrc, output_sample_rate;
  logic signed [11:0] corrX, corrY, corrZ;
  integer seed = 32'h5331, fail_count = 0, check_count = 0, i;

  motion_event_wake_controller #(.W(12), .TOUT_W(16))
    u_motion_event_wake_controller (.*);
  host_model u_host_model (.*);

  initial forever #10 clock = ~clock;

  function automatic logic [7:0] osrExp(input logic [1:0] m);
    case (m)
      `OSM_HIRES:    osrExp = `OSR_HIRES;
      `OSM_LOWPOWER: osrExp = `OSR_LOWPOWER;
      `OSM_LOWNOISE: osrExp = `OSR_LOWNOISE;
      default:       osrExp = `OSR_NORMAL;
    endcase
  endfunction

  // Event on X only: axis flag, sign, event-active bit
  function automatic logic [6:0] motExp(input logic signed [11:0] x);
    motExp = {5'h10, 1'b1, x[11]};
  endfunction

  function automatic logic signed [11:0] corrExp(
      input logic signed [11:0] r, t, input logic signed [7:0] o);
    corrExp = r + t + {{4{o[7]}}, o};
  endfunction

  task automatic smp(input logic signed [11:0] x, y, z);
    @(posedge clock);
    sampleValid <= 1'b1;
    bufEvent <= bufOn;
    {rawX, rawY, rawZ} <= {x, y, z};
    @(posedge clock);
    sampleValid <= 1'b0;
    bufEvent <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Lets the host drain all flags while it rolls the unused settings
  task automatic clr;
    @(posedge clock);
    svcOn <= 1'b1;
    {tapAxisEn, tapDoubleEn, tapHpEn, tapLpEn, hpCutoff} <= 8'($random(seed));
    {tapWindow, tapLatency, oversampling_mode_sleep} <= 18'($random(seed));
    {tapThrX, tapThrY} <= 24'($random(seed));
    {tapThrZ, oriMidThr} <= 24'($random(seed));
    {oriHyst, zLockThr} <= 24'($random(seed));
    {bufGate, lag} <= 5'($random(seed)) & 5'h13;
    repeat (12) @(posedge clock);
    svcOn <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    wrap_up;
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      oversampling_mode_select <= i[1:0];
      repeat (4) @(posedge clock);
      #1;
      `CHK(osRatio, osrExp(i[1:0]))
    end
    $display("test oversampling done");
    clr;
    @(posedge clock);
    {intEnable, interrupt_pin_route_config, svcOn} <= {8'h01, 8'h01, 1'b1};
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      {trimX, userOffX} <= {12'($random(seed) % 64), 8'($random(seed) % 64)};
      {trimY, userOffY} <= {12'($random(seed) % 64), 8'($random(seed) % 64)};
      {trimZ, userOffZ} <= {12'($random(seed) % 64), 8'($random(seed) % 64)};
      smp(12'($random(seed) % 512), 12'($random(seed) % 512),
          12'($random(seed) % 512));
      `CHK(corrX, corrExp(rawX, trimX, userOffX))
      `CHK(corrY, corrExp(rawY, trimY, userOffY))
      `CHK(corrZ, corrExp(rawZ, trimZ, userOffZ))
    end
    $display("test offsets done");
    clr;
    @(posedge clock);
    {intEnable, interrupt_pin_route_config} <= {8'h04, 8'h04};
    {ffMotSelMotion, ffMotAxisEn, ffMotThr} <= {1'b1, 3'h1, 12'h100};
    {trimX, trimY, trimZ, userOffX, userOffY, userOffZ} <= '0;
    for (i = 0; i < 2; i++) begin
      smp(i ? -BIG : BIG, NIL, NIL);
      `CHK(motionSrc, motExp(rawX))
      `CHK(interrupt_out_a, 1'b1)
      smp(NIL, NIL, NIL);
      `CHK(intSource[`SRC_MOTION], 1'b1)
      clr;
      `CHK(interrupt_out_a, 1'b0)
    end
    @(posedge clock);
    ffMotCount <= 8'h03;
    repeat (2) smp(BIG, NIL, NIL);
    `CHK(intSource[`SRC_MOTION], 1'b0)
    smp(BIG, NIL, NIL);
    `CHK(intSource[`SRC_MOTION], 1'b1)
    clr;
    @(posedge clock);
    {intEnable, ffMotCount} <= 16'h0000;
    smp(BIG, NIL, NIL);
    `CHK(intSource[`SRC_MOTION], 1'b0)
    `CHK(interrupt_out_a, 1'b0)
    @(posedge clock);
    {intEnable, ffMotSelMotion, ffMotAxisEn} <= {8'h04, 1'b0, 3'h7};
    smp(NIL, NIL, NIL);
    `CHK(intSource[`SRC_MOTION], 1'b1)
    $display("test motion and freefall done");
    for (i = 0; i < 2; i++) begin
      clr;
      @(posedge clock);
      {intEnable, interrupt_pin_route_config} <= {8'h20, 8'(i << 5)};
      {transHpBypass, transAxisEn, transThr} <= {1'b1, 3'h1, 12'h100};
      smp(BIG, NIL, NIL);
      `CHK(intSource[`SRC_TRANS], 1'b1)
      `CHK(transSrc, motExp(rawX))
      `CHK(interrupt_out_a, i[0])
      `CHK(interrupt_out_b, !i[0])
    end
    $display("test transient done");
    @(posedge clock);
    {intEnable, oriMidThr, oriHyst} <= {8'h10, 12'h100, 12'h000};
    zLockThr <= 12'hfff;
    smp(NIL, BIG, NIL);
    smp(NIL, -BIG, NIL);
    `CHK(orientSrc, `ORI_PORT_DN)
    `CHK(intSource[`SRC_ORIENT], 1'b1)
    @(posedge clock);
    zLockThr <= 12'h100;
    smp(BIG, NIL, BIG);
    `CHK(orientSrc, `ORI_PORT_DN)
    $display("test orientation done");
    // Mid-run reset clears any tap state left by the rolled settings
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    {intEnable, tapAxisEn, tapDoubleEn, tapHpEn, tapLpEn} <= 14'h0208;
    {tapThrX, tapWindow} <= {12'h100, 8'h04};
    smp(BIG, NIL, NIL);
    smp(NIL, NIL, NIL);
    `CHK(tapSrc, 8'h88)
    `CHK(intSource[`SRC_TAP], 1'b1)
    $display("test tap done");
    clr;
    @(posedge clock);
    {intEnable, ffMotSelMotion, ffMotAxisEn} <= {8'h44, 1'b1, 3'h1};
    {autoSleepEn, sleepTimeout, wakeRate, sleepRate} <= {17'h10004, 6'o16};
    {wakeSrcEn, bufOn} <= {4'h2, 1'b1};
    bufGate <= 1'b1;
    repeat (10) smp(NIL, NIL, NIL);
    `CHK(sleepState, 1'b0)
    @(posedge clock);
    intEnable <= 8'h04;
    repeat (8) smp(NIL, NIL, NIL);
    `CHK(sleepState, 1'b1)
    `CHK(output_sample_rate, sleepRate)
    `CHK(bufHold, 1'b1)
    @(posedge clock);
    intEnable <= 8'h44;
    repeat (2) smp(NIL, NIL, NIL);
    `CHK(sleepState, 1'b1)
    smp(BIG, NIL, NIL);
    `CHK(sleepState, 1'b0)
    `CHK(output_sample_rate, wakeRate)
    `CHK(bufHold, 1'b1)
    $display("test auto sleep done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
